// >>> rtl/adoc_pkg.sv
package adoc_pkg;

  // ---------------------------------------------------------------
  // clock and sample timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int UNF_RATE_HZ = 2000;
  localparam int UNF_CYCLES = CLK_HZ / UNF_RATE_HZ;
  localparam int FILT_MAX_BW_HZ = 1000;
  localparam int FILT_MIN_CYCLES = CLK_HZ / (2 * FILT_MAX_BW_HZ);
  localparam int TMR_W = 24;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_X_LOW = 6'h02;
  localparam logic [5:0] IDX_X_HIGH = 6'h03;
  localparam logic [5:0] IDX_Y_LOW = 6'h04;
  localparam logic [5:0] IDX_Y_HIGH = 6'h05;
  localparam logic [5:0] IDX_Z_LOW = 6'h06;
  localparam logic [5:0] IDX_Z_HIGH = 6'h07;
  localparam logic [5:0] IDX_TEMP = 6'h08;
  localparam logic [5:0] IDX_RANGE = 6'h0F;
  localparam logic [5:0] IDX_BAND = 6'h10;
  localparam logic [5:0] IDX_STREAM = 6'h13;
  localparam logic [5:0] IDX_SELFTEST = 6'h32;
  localparam logic [5:0] IDX_COMP_CTRL = 6'h36;
  localparam logic [5:0] IDX_COMP_SETUP = 6'h37;
  localparam logic [5:0] IDX_FILT_X_CORR = 6'h38;
  localparam logic [5:0] IDX_FILT_Y_CORR = 6'h39;
  localparam logic [5:0] IDX_FILT_Z_CORR = 6'h3A;
  localparam logic [5:0] IDX_RAW_X_CORR = 6'h3B;
  localparam logic [5:0] IDX_RAW_Y_CORR = 6'h3C;
  localparam logic [5:0] IDX_RAW_Z_CORR = 6'h3D;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LOW_NEW_BIT = 0;
  localparam int LOW_DATA_LSB = 6;
  localparam int STREAM_UNF_BIT = 7;
  localparam int STREAM_SHADOW_DIS_BIT = 6;
  localparam int ST_SIGN_BIT = 2;
  localparam int CTRL_CLEAR_BIT = 7;
  localparam int CTRL_TRIG_LSB = 5;
  localparam int CTRL_RDY_BIT = 4;
  localparam int SETUP_PERIOD_BIT = 0;
  localparam int SETUP_TGT_LSB = 1;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [3:0] RANGE_RST = 4'h3;
  localparam logic [4:0] BAND_RST = 5'h1F;
  localparam logic [4:0] SLOW_PERIOD_SHORT = 5'h08;
  localparam logic [4:0] SLOW_PERIOD_LONG = 5'h10;
  localparam logic [3:0] FAST_LAST = 4'hF;
  localparam logic [9:0] SLOW_STEP = 10'h004;
  localparam logic [9:0] ONE_G_2G = 10'h100;

  typedef enum logic {ADOC_IDLE, ADOC_RUN} adoc_fast_e;

endpackage

// >>> rtl/adoc_core.sv
`timescale 1ns/100ps
// Behaviour
// (R1) axis sample 10-bit signed; high byte bits 9..2, low bits 1..0 plus flag
// (R2) reader fetches the low byte of an axis before its high byte
// (R3) with shadowing, high byte refreshes only when its low byte is read
// (R4) shadow disable bit 1 makes both bytes take every new sample at once
// (R5) new-sample flag set on update, cleared by reading either byte of axis
// (R6) unfiltered stream at 2 kHz, filtered at twice the selected bandwidth
// (R7) stream bit 0 routes filtered, 1 unfiltered; each stream own offset
// (R8) band codes 01000..01111 select 7.81..1000 Hz; 00xxx low, 1xxxx high
// (R9) range codes 0011, 0101, 1000, 1100 select 2g, 4g, 8g, 16g
// (R10) temperature is 8-bit signed, 0.5 K per step, zero at 24 C
// (R11) self-test axis field 01 x, 10 y, 11 z, 00 off
// (R12) self-test sign bit 0 deflects positive, 1 negative
// (R13) offset added to each converter sample per stream, saturated
// (R14) public 8-bit offset widened to 10-bit internal; read back saturated
// (R15) target code 00 or 11 gives 0g, 01 gives +1g, 10 gives -1g
// (R16) writing 1 to offset clear sets every offset to zero
// (R17) slow mode steps offset by 4 after a full period above or below target
// (R18) slow mode per enabled axis; period 8 or 16 samples by select bit
// (R19) fast mode averages 16 samples, stores target minus average as offset
// (R20) trigger 01/10/11 starts fast on x/y/z; busy, not ready, slow halted
// (R21) host does not write offsets while slow enabled or fast running
// (R22) stored image values load into the offsets after every reset
// (R23) fast mode end returns trigger to 00 and sets ready
module adoc_core #(
  parameter int UNF_CYC = adoc_pkg::UNF_CYCLES,
  parameter int FILT_CYC = adoc_pkg::FILT_MIN_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter samples, filtered stream
  input wire logic signed [9:0] filt_x,
  input wire logic signed [9:0] filt_y,
  input wire logic signed [9:0] filt_z,
  // converter samples, unfiltered stream
  input wire logic signed [9:0] unf_x,
  input wire logic signed [9:0] unf_y,
  input wire logic signed [9:0] unf_z,
  // temperature sensor
  input wire logic [7:0] temp_in,
  // stored offset images
  input wire logic [7:0] nvm_filt_x,
  input wire logic [7:0] nvm_filt_y,
  input wire logic [7:0] nvm_filt_z,
  input wire logic [7:0] nvm_raw_x,
  input wire logic [7:0] nvm_raw_y,
  input wire logic [7:0] nvm_raw_z,
  // analog front end controls
  output logic [1:0] range_sel,
  output logic [2:0] band_sel,
  output logic [2:0] st_excite,
  output logic st_negative,
  output logic data_update
);
  import adoc_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic signed [9:0] sat10(input logic signed [14:0] v);
    if (v > 15'sh01FF) begin
      sat10 = 10'sh1FF;
    end else if (v < 15'sh7E00) begin
      sat10 = 10'sh200;
    end else begin
      sat10 = v[9:0];
    end
  endfunction

  function automatic logic signed [9:0] add_sat(input logic signed [9:0] d,
      input logic signed [9:0] o, input logic [1:0] sh);
    logic signed [9:0] os;
    os = o >>> sh;
    add_sat = sat10(15'(d) + 15'(os));
  endfunction

  function automatic logic [7:0] narrow(input logic signed [9:0] o);
    logic signed [8:0] h;
    h = 9'(o >>> 1);
    if (h > 9'sh07F) begin
      narrow = 8'h7F;
    end else if (h < 9'sh180) begin
      narrow = 8'h80;
    end else begin
      narrow = h[7:0];
    end
  endfunction

  function automatic logic signed [9:0] widen(input logic [7:0] p);
    widen = {p[7], p, 1'b0};
  endfunction

  function automatic logic [1:0] range_shift(input logic [3:0] c);
    case (c)
      4'h3: range_shift = 2'h0;
      4'h5: range_shift = 2'h1;
      4'h8: range_shift = 2'h2;
      4'hC: range_shift = 2'h3;
      default: range_shift = 2'h0;
    endcase
  endfunction

  function automatic logic [2:0] band_idx(input logic [4:0] c);
    if (c[4]) begin
      band_idx = 3'h7;
    end else if (!c[3]) begin
      band_idx = 3'h0;
    end else begin
      band_idx = c[2:0];
    end
  endfunction

  function automatic logic signed [9:0] target(input logic [1:0] c,
      input logic [1:0] sh);
    logic signed [9:0] g;
    g = $signed(ONE_G_2G) >>> sh;
    case (c)
      2'h1: target = g;
      2'h2: target = -g;
      default: target = 10'sh000;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [3:0] range_q;
  logic [4:0] band_q;
  logic unf_sel_q, shadow_dis_q;
  logic [1:0] st_axis_q;
  logic st_sign_q;
  logic [2:0] track_q;
  logic period_q;
  logic [1:0] tgt_q [3];
  logic [1:0] trig_q, trig_d;
  logic rdy_q, rdy_d;
  adoc_fast_e fast_q, fast_d;
  logic [3:0] fcnt_q, fcnt_d;
  logic signed [13:0] facc_q, facc_d;
  logic signed [9:0] off_q [2][3];
  logic signed [9:0] off_d [2][3];
  logic [4:0] scnt_q [3];
  logic [4:0] scnt_d [3];
  logic sdir_q [3];
  logic sdir_d [3];
  logic [9:0] lat_q [3];
  logic [1:0] lowd_q [3];
  logic [7:0] high_q [3];
  logic new_q [3];
  logic [7:0] temp_q;
  logic load_q;
  logic [TMR_W-1:0] utmr_q, ftmr_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire [5:0] idx = paddr[7:2];
  wire acc_first = psel && penable && !pready;
  wire acc_done = psel && penable && pready;
  wire wr_done = acc_done && pwrite && pstrb[0] && paddr[1:0] == 2'h0;
  wire rd_first = acc_first && !pwrite && paddr[1:0] == 2'h0;
  wire [7:0] wb = pwdata[7:0];
  wire wr_ctrl = wr_done && idx == IDX_COMP_CTRL;
  wire [1:0] wr_trig = wb[CTRL_TRIG_LSB +: 2];
  wire [1:0] sh = range_shift(range_q);

  // ---------------------------------------------------------------
  // sample strobes
  // ---------------------------------------------------------------
  wire [2:0] bidx = band_idx(band_q); // (R8)
  wire [TMR_W-1:0] fper = TMR_W'(FILT_CYC) << (3'h7 - bidx); // (R6)
  wire unf_stb = utmr_q == '0;
  wire filt_stb = ftmr_q == '0;
  wire sel_stb = unf_sel_q ? unf_stb : filt_stb; // (R7)
  wire sidx = unf_sel_q;

  // ---------------------------------------------------------------
  // compensated samples
  // ---------------------------------------------------------------
  logic signed [9:0] raw_s [2][3];
  logic signed [9:0] comp_s [2][3];
  logic signed [9:0] sel_raw [3];
  logic signed [9:0] sel_comp [3];
  logic signed [9:0] tgt_v [3];
  assign raw_s[0][0] = filt_x;
  assign raw_s[0][1] = filt_y;
  assign raw_s[0][2] = filt_z;
  assign raw_s[1][0] = unf_x;
  assign raw_s[1][1] = unf_y;
  assign raw_s[1][2] = unf_z;

  always_comb begin
    for (int s = 0; s < 2; s++) begin
      for (int a = 0; a < 3; a++) begin
        comp_s[s][a] = add_sat(raw_s[s][a], off_q[s][a], sh); // (R13)
      end
    end
    for (int a = 0; a < 3; a++) begin
      sel_raw[a] = raw_s[sidx][a];
      sel_comp[a] = comp_s[sidx][a];
      tgt_v[a] = target(tgt_q[a], sh); // (R15)
    end
  end

  // ---------------------------------------------------------------
  // fast compensation
  // ---------------------------------------------------------------
  wire [1:0] fax = trig_q - 2'h1;
  wire signed [13:0] facc_n = facc_q + 14'(sel_raw[fax]);
  wire signed [9:0] favg = 10'(facc_n >>> 4);
  wire signed [14:0] fdiff = 15'(tgt_v[fax]) - 15'(favg);
  wire signed [9:0] fres = sat10(15'(fdiff <<< sh));
  wire fast_end = fast_q == ADOC_RUN && sel_stb && fcnt_q == FAST_LAST;

  always_comb begin
    fast_d = fast_q;
    trig_d = trig_q;
    rdy_d = rdy_q;
    fcnt_d = fcnt_q;
    facc_d = facc_q;
    case (fast_q)
      ADOC_IDLE: begin
        if (wr_ctrl && wr_trig != 2'h0) begin
          fast_d = ADOC_RUN; // (R20)
          trig_d = wr_trig;
          rdy_d = 1'b0;
          fcnt_d = 4'h0;
          facc_d = 14'sh0000;
        end
      end
      ADOC_RUN: begin
        if (sel_stb) begin
          facc_d = facc_n; // (R19)
          fcnt_d = fcnt_q + 4'h1;
        end
        if (fast_end) begin
          fast_d = ADOC_IDLE; // (R23)
          trig_d = 2'h0;
          rdy_d = 1'b1;
        end
      end
      default: fast_d = ADOC_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // offsets and slow compensation
  // ---------------------------------------------------------------
  logic [7:0] nvm_img [2][3];
  assign nvm_img[0][0] = nvm_filt_x;
  assign nvm_img[0][1] = nvm_filt_y;
  assign nvm_img[0][2] = nvm_filt_z;
  assign nvm_img[1][0] = nvm_raw_x;
  assign nvm_img[1][1] = nvm_raw_y;
  assign nvm_img[1][2] = nvm_raw_z;
  wire [4:0] sper = period_q ? SLOW_PERIOD_LONG : SLOW_PERIOD_SHORT;

  always_comb begin
    logic above, below;
    logic [4:0] nc;
    logic signed [9:0] o;
    above = 1'b0;
    below = 1'b0;
    nc = 5'h00;
    o = 10'sh000;
    off_d = off_q;
    scnt_d = scnt_q;
    sdir_d = sdir_q;
    for (int s = 0; s < 2; s++) begin
      for (int a = 0; a < 3; a++) begin
        if (wr_done && idx == IDX_FILT_X_CORR + 6'(3 * s + a)) begin
          off_d[s][a] = widen(wb); // (R14)
        end
      end
    end
    for (int a = 0; a < 3; a++) begin
      above = sel_comp[a] > tgt_v[a];
      below = sel_comp[a] < tgt_v[a];
      nc = (sdir_q[a] == above) ? scnt_q[a] + 5'h01 : 5'h01;
      o = off_q[sidx][a];
      if (sel_stb && track_q[a] && fast_q == ADOC_IDLE) begin // (R18)
        if (!above && !below) begin
          scnt_d[a] = 5'h00;
        end else if (nc == sper) begin
          scnt_d[a] = 5'h00; // (R17)
          off_d[sidx][a] = above ? sat10(15'(o) - 15'(SLOW_STEP))
                                 : sat10(15'(o) + 15'(SLOW_STEP));
        end else begin
          scnt_d[a] = nc;
        end
        sdir_d[a] = above;
      end
    end
    if (fast_end) begin
      off_d[sidx][fax] = fres; // (R19)
    end
    if (wr_ctrl && wb[CTRL_CLEAR_BIT]) begin
      off_d = '{default: 10'sh000}; // (R16)
    end
    if (load_q) begin
      for (int s = 0; s < 2; s++) begin
        for (int a = 0; a < 3; a++) begin
          off_d[s][a] = widen(nvm_img[s][a]); // (R22)
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [7:0] rd_byte;
  logic hit;
  always_comb begin
    hit = paddr[1:0] == 2'h0;
    case (idx)
      IDX_X_LOW: rd_byte = {lowd_q[0], 5'h00, new_q[0]}; // (R1)
      IDX_Y_LOW: rd_byte = {lowd_q[1], 5'h00, new_q[1]};
      IDX_Z_LOW: rd_byte = {lowd_q[2], 5'h00, new_q[2]};
      IDX_X_HIGH: rd_byte = high_q[0];
      IDX_Y_HIGH: rd_byte = high_q[1];
      IDX_Z_HIGH: rd_byte = high_q[2];
      IDX_TEMP: rd_byte = temp_q; // (R10)
      IDX_RANGE: rd_byte = {4'h0, range_q};
      IDX_BAND: rd_byte = {3'h0, band_q};
      IDX_STREAM: rd_byte = {unf_sel_q, shadow_dis_q, 6'h00};
      IDX_SELFTEST: rd_byte = {5'h00, st_sign_q, st_axis_q};
      IDX_COMP_CTRL: rd_byte = {1'b0, trig_q, rdy_q, 1'b0, track_q};
      IDX_COMP_SETUP: rd_byte = {1'b0, tgt_q[2], tgt_q[1], tgt_q[0], period_q};
      IDX_FILT_X_CORR: rd_byte = narrow(off_q[0][0]); // (R14)
      IDX_FILT_Y_CORR: rd_byte = narrow(off_q[0][1]);
      IDX_FILT_Z_CORR: rd_byte = narrow(off_q[0][2]);
      IDX_RAW_X_CORR: rd_byte = narrow(off_q[1][0]);
      IDX_RAW_Y_CORR: rd_byte = narrow(off_q[1][1]);
      IDX_RAW_Z_CORR: rd_byte = narrow(off_q[1][2]);
      default: begin
        rd_byte = 8'h00;
        hit = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc_first;
      pslverr <= acc_first && !hit;
      if (acc_first) begin
        prdata <= pwrite || !hit ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_q <= RANGE_RST;
      band_q <= BAND_RST;
      unf_sel_q <= 1'b0;
      shadow_dis_q <= 1'b0;
      st_axis_q <= 2'h0;
      st_sign_q <= 1'b0;
      track_q <= 3'h0;
      period_q <= 1'b0;
      tgt_q <= '{default: 2'h0};
    end else if (wr_done) begin
      case (idx)
        IDX_RANGE: range_q <= wb[3:0]; // (R9)
        IDX_BAND: band_q <= wb[4:0];
        IDX_STREAM: begin
          unf_sel_q <= wb[STREAM_UNF_BIT]; // (R7)
          shadow_dis_q <= wb[STREAM_SHADOW_DIS_BIT]; // (R4)
        end
        IDX_SELFTEST: begin
          st_axis_q <= wb[1:0];
          st_sign_q <= wb[ST_SIGN_BIT];
        end
        IDX_COMP_CTRL: track_q <= wb[2:0];
        IDX_COMP_SETUP: begin
          period_q <= wb[SETUP_PERIOD_BIT];
          for (int a = 0; a < 3; a++) begin
            tgt_q[a] <= wb[SETUP_TGT_LSB + 2 * a +: 2];
          end
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // compensation engine state
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_q <= ADOC_IDLE;
      trig_q <= 2'h0;
      rdy_q <= 1'b1;
      fcnt_q <= 4'h0;
      facc_q <= 14'sh0000;
      off_q <= '{default: 10'sh000};
      scnt_q <= '{default: 5'h00};
      sdir_q <= '{default: 1'b0};
      load_q <= 1'b1;
    end else begin
      fast_q <= fast_d;
      trig_q <= trig_d;
      rdy_q <= rdy_d;
      fcnt_q <= fcnt_d;
      facc_q <= facc_d;
      off_q <= off_d;
      scnt_q <= scnt_d;
      sdir_q <= sdir_d;
      load_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sample timers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      utmr_q <= '0;
      ftmr_q <= '0;
    end else begin
      utmr_q <= unf_stb ? TMR_W'(UNF_CYC - 1) : utmr_q - 1'b1; // (R6)
      ftmr_q <= filt_stb ? fper - 1'b1 : ftmr_q - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // data registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_q <= '{default: 10'h000};
      lowd_q <= '{default: 2'h0};
      high_q <= '{default: 8'h00};
      new_q <= '{default: 1'b0};
    end else begin
      for (int a = 0; a < 3; a++) begin
        if (sel_stb) begin
          lat_q[a] <= sel_comp[a];
          lowd_q[a] <= sel_comp[a][1:0]; // (R1)
          new_q[a] <= 1'b1; // (R5)
        end else if (rd_first && (idx == IDX_X_LOW + 6'(2 * a) ||
                                  idx == IDX_X_HIGH + 6'(2 * a))) begin
          new_q[a] <= 1'b0; // (R5)
        end
        if (sel_stb && shadow_dis_q) begin
          high_q[a] <= sel_comp[a][9:2]; // (R4)
        end else if (!shadow_dis_q && rd_first &&
                     idx == IDX_X_LOW + 6'(2 * a)) begin
          high_q[a] <= lat_q[a][9:2]; // (R3)
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // front end outputs
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_q <= 8'h00;
      range_sel <= 2'h0;
      band_sel <= 3'h0;
      st_excite <= 3'h0;
      st_negative <= 1'b0;
      data_update <= 1'b0;
    end else begin
      temp_q <= temp_in; // (R10)
      range_sel <= sh; // (R9)
      band_sel <= bidx; // (R8)
      st_excite <= st_axis_q == 2'h0 ? 3'h0
                                     : 3'h1 << (st_axis_q - 2'h1); // (R11)
      st_negative <= st_sign_q; // (R12)
      data_update <= sel_stb;
    end
  end

endmodule

// >>> testbench/adoc_core_properties.sv
`timescale 1ns/100ps
// ------------------------------------------
// bus and output checks
// ------------------------------------------
module adoc_checker #(
  parameter int UNF_CYC = 8,
  parameter int FILT_CYC = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // front end
  input wire logic [1:0] range_sel,
  input wire logic [2:0] band_sel,
  input wire logic [2:0] st_excite,
  input wire logic data_update
);
  wire logic acc;
  wire logic wr_done;
  assign acc = psel && penable;
  assign wr_done = acc && pready && pwrite && pstrb[0];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not one cycle after access start");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unaligned: assert property (
    acc && pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access without error");
  a_err_unmapped: assert property (
    acc && pready && paddr[7:2] == 6'h3F |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_low_unused: assert property (
    acc && pready && !pwrite && paddr == 8'h08
    |-> prdata[31:8] == 24'h0 && prdata[5:1] == 5'h00)
    else $error("unused low byte bits set");
  a_range_code: assert property (
    wr_done && paddr == 8'h3C && pwdata[3:0] == 4'h5
    |-> ##[1:2] range_sel == 2'h1)
    else $error("range code not decoded");
  a_band_high: assert property (
    wr_done && paddr == 8'h40 && pwdata[4] |-> ##[1:2] band_sel == 3'h7)
    else $error("high band code not decoded");
  a_excite_axis: assert property (
    wr_done && paddr == 8'hC8 && pwdata[1:0] == 2'h2
    |-> ##[1:2] st_excite == 3'h2)
    else $error("self test axis not decoded");
  a_update_gap: assert property (data_update |=> !data_update)
    else $error("update pulse too long");
endmodule
bind adoc_core adoc_checker #(.UNF_CYC(UNF_CYC), .FILT_CYC(FILT_CYC)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .range_sel(range_sel), .band_sel(band_sel), .st_excite(st_excite),
  .data_update(data_update));

// >>> testbench/testbench.sv
`timescale 1ns/100ps
// ------------------------------------------
// register bench
// ------------------------------------------
module testbench;
  import adoc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h1;
  logic [7:0] tmp = 8'h2A;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, err, data_update, st_negative;
  logic [1:0] range_sel;
  logic [2:0] band_sel, st_excite;
  logic signed [9:0] fx = 10'h000, fy = 10'h1FF, ux = 10'h010;
  logic [7:0] nv [6] = '{8'h05, 8'h7F, 8'h83, 8'h11, 8'h22, 8'h33};
  logic [7:0] bc [10] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
    8'h0E, 8'h0F, 8'h00, 8'h1F};
  logic [7:0] rc [5] = '{8'h03, 8'h05, 8'h08, 8'h0C, 8'h07};
  int fail_count = 0;
  int tests_run = 0;
  int n;
  always #12.5 pclk = ~pclk;
  adoc_core #(.UNF_CYC(8), .FILT_CYC(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .filt_x(fx), .filt_y(fy), .filt_z(10'h000), .unf_x(ux),
    .unf_y(10'h000), .unf_z(10'h000), .temp_in(tmp),
    .nvm_filt_x(nv[0]), .nvm_filt_y(nv[1]), .nvm_filt_z(nv[2]),
    .nvm_raw_x(nv[3]), .nvm_raw_y(nv[4]), .nvm_raw_z(nv[5]),
    .range_sel(range_sel), .band_sel(band_sel), .st_excite(st_excite),
    .st_negative(st_negative), .data_update(data_update));
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
      if (k > 20) begin
        fail_count++;
        test_done();
      end
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    apb(1'b0, {i, 2'b00}, 8'h00);
    chk(rdat, {24'h0, e});
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask
  // two update pulses so the value set before is surely taken
  task automatic wsamp;
    int k;
    for (int j = 0; j < 2; j++) begin
      k = 0;
      do begin
        @(posedge pclk);
        k++;
        if (k > 2000) begin
          fail_count++;
          test_done();
        end
      end while (data_update !== 1'b1);
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_RANGE, 8'h03);
    rd(IDX_BAND, 8'h1F);
    rd(IDX_COMP_CTRL, 8'h10);
    rd(IDX_TEMP, 8'h2A);
    for (int i = 0; i < 6; i++) rd(6'(IDX_FILT_X_CORR + i), nv[i]);
    apb(1'b0, 8'hFC, 8'h00);
    chk(err, 1'b1);
    apb(1'b0, 8'h09, 8'h00);
    chk(err, 1'b1);
    wr(IDX_TEMP, 8'h55);
    rd(IDX_TEMP, 8'h2A);
    tmp <= 8'hD6;
    rd(IDX_TEMP, 8'hD6);
    pstrb <= 4'h0;
    wr(IDX_RANGE, 8'h05);
    pstrb <= 4'h1;
    rd(IDX_RANGE, 8'h03);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      wr(IDX_BAND, bc[i]);
      repeat (2) @(posedge pclk);
      chk(band_sel, (i < 8) ? i[2:0] : {3{i[0]}});
    end
    for (int i = 0; i < 5; i++) begin
      wr(IDX_RANGE, rc[i]);
      repeat (2) @(posedge pclk);
      chk(range_sel, (i < 4) ? i[1:0] : 2'h0);
    end
    for (int i = 0; i < 8; i++) begin
      wr(IDX_SELFTEST, 8'(i));
      repeat (2) @(posedge pclk);
      chk(st_excite, i[1:0] == 0 ? 3'h0 : 3'h1 << (i[1:0] - 1));
      chk(st_negative, i[2]);
    end
    wr(IDX_RANGE, 8'h03);
    $display("test controls done");
    wr(IDX_BAND, 8'h08);
    fx <= 10'h123;
    wsamp();
    rd(IDX_X_LOW, 8'h41);
    rd(IDX_X_LOW, 8'h40);
    rd(IDX_X_HIGH, 8'h4B);
    rd(IDX_Y_LOW, 8'hC1);
    rd(IDX_Y_HIGH, 8'h7F);
    rd(IDX_Y_LOW, 8'hC0);
    fx <= 10'h000;
    wsamp();
    rd(IDX_X_HIGH, 8'h4B);
    rd(IDX_X_LOW, 8'h80);
    rd(IDX_X_HIGH, 8'h02);
    wr(IDX_STREAM, 8'h40);
    fx <= 10'h3F0;
    wsamp();
    rd(IDX_X_HIGH, 8'hFE);
    $display("test data done");
    wr(IDX_COMP_CTRL, 8'h80);
    for (int i = 0; i < 6; i++) rd(6'(IDX_FILT_X_CORR + i), 8'h00);
    rd(IDX_COMP_CTRL, 8'h10);
    $display("test clear done");
    wr(IDX_STREAM, 8'h80);
    wr(IDX_COMP_SETUP, 8'h02);
    wr(IDX_COMP_CTRL, 8'h20);
    rd(IDX_COMP_CTRL, 8'h20);
    n = 0;
    do begin
      apb(1'b0, {IDX_COMP_CTRL, 2'b00}, 8'h00);
      n++;
    end while (rdat[4] !== 1'b1 && n < 200);
    chk(rdat, 32'h10);
    rd(IDX_RAW_X_CORR, 8'h78);
    wsamp();
    rd(IDX_X_LOW, 8'h01);
    rd(IDX_X_HIGH, 8'h40);
    $display("test fast done");
    ux <= 10'h064;
    wr(IDX_COMP_CTRL, 8'h01);
    n = 0;
    do begin
      apb(1'b0, {IDX_RAW_X_CORR, 2'b00}, 8'h00);
      n++;
    end while (rdat === 32'h78 && n < 100);
    chk(rdat, 32'h76);
    wr(IDX_COMP_CTRL, 8'h00);
    wr(IDX_RAW_Y_CORR, 8'h85);
    rd(IDX_RAW_Y_CORR, 8'h85);
    $display("test slow done");
    test_done();
  end
endmodule
